// ===== hdl/dsrf_regs.vh
// Overview of operation
// RQ1: accepted command answers stx, two address chars, ack 0x06, check code, cr.
// RQ2: affirmative check code is xor of address chars and ack only.
// RQ3: rejected command answers stx, address, nak 0x15, two-char error code, check, cr.
// RQ4: negative check code is xor of address chars, error chars and nak.
// RQ5: line faults: parity 01h, checksum 02h, framing 03h, overrun 04h, protocol 05h, ascii 06h.
// RQ6: other faults: buffer 07h, timeout 08h, command 11h, disabled 13h, parameter 16h.
// RQ7: broadcast commands are executed but never answered.
// RQ8: address ff means broadcast; stations use 01 to 32.
// RQ9: check code xors first two bytes then each later byte in order.
// RQ10: digits 30-39, a-f 41-46, h 48, p 50, lowercase b 62.
// RQ11: speed select 02 runs a loopback self-test at power-up, no jumper; here the power-up check sees the reset value 04, so only ctrl bit 0 starts it.
// RQ12: loopback repeats each power-up while selected; default speed select 04; here reset always reloads 04, so it never runs at power-up.
// RQ13: modbus mode only responds after a query, never initiates; here a reply write in modbus mode sends a frame without any query.
// RQ14: query not complete within timeout is discarded unanswered, wait restarts.
// RQ15: timeout action: 00 trip, 01 decel then trip, 02 ignore, 03 coast, 04 decel.
// RQ16: timeout supervision starts at first exchange after reset, only while active.
// RQ17: reception timeout limit ranges zero to 99.99 seconds.
// RQ18: response delayed by wait time 0.0 to 1000 ms after query end.
// RQ19: silent interval of 3.5 characters is added to the wait time.
// RQ20: reception timeout counted in 10 ms steps.
// RQ21: frames for other addresses are ignored silently.
`ifndef DSRF_REGS_VH
`define DSRF_REGS_VH
// ****************************************
// register offsets
// ****************************************
`define DSRF_OFF_CTRL     12'h000
`define DSRF_OFF_CONFIG   12'h004
`define DSRF_OFF_TIMING   12'h008
`define DSRF_OFF_REPLY    12'h00c
`define DSRF_OFF_STATUS   12'h010
// ****************************************
// field positions
// ****************************************
`define DSRF_CFG_ADDR_LSB   0
`define DSRF_CFG_SPEED_LSB  8
`define DSRF_CFG_ACTION_LSB 16
`define DSRF_CFG_MODBUS_BIT 24
`define DSRF_TIM_WAIT_LSB   0
`define DSRF_TIM_LIMIT_LSB  16
// ****************************************
// reset values
// ****************************************
`define DSRF_RST_ADDR     8'h01
`define DSRF_RST_SPEED    8'h04
`define DSRF_RST_ACTION   8'h00
`define DSRF_RST_WAIT     16'h0000
`define DSRF_RST_LIMIT    16'h0000
// ****************************************
// protocol characters and codes
// ****************************************
`define DSRF_STX          8'h02
`define DSRF_ACK          8'h06
`define DSRF_CR           8'h0d
`define DSRF_NAK          8'h15
`define DSRF_BCAST        8'hff
`define DSRF_SPEED_LOOP   8'h02
`define DSRF_ERR_PARITY   8'h01
`define DSRF_ERR_CHECKSUM 8'h02
`define DSRF_ERR_FRAMING  8'h03
`define DSRF_ERR_OVERRUN  8'h04
`define DSRF_ERR_PROTOCOL 8'h05
`define DSRF_ERR_ASCII    8'h06
`define DSRF_ERR_BUFFER   8'h07
`define DSRF_ERR_TIMEOUT  8'h08
`define DSRF_ERR_COMMAND  8'h11
`define DSRF_ERR_DISABLED 8'h13
`define DSRF_ERR_PARAM    8'h16
`define DSRF_ACT_TRIP     8'h00
`define DSRF_ACT_DECTRIP  8'h01
`define DSRF_ACT_IGNORE   8'h02
`define DSRF_ACT_COAST    8'h03
`define DSRF_ACT_DECEL    8'h04
// ****************************************
// timing
// ****************************************
`define DSRF_CLK_KHZ      125000
`define DSRF_TICK_US      100
`define DSRF_TICK_CYC     (`DSRF_CLK_KHZ * `DSRF_TICK_US / 1000)
`define DSRF_STEP_TICKS   100
`define DSRF_LIMIT_MAX    16'd9999
`define DSRF_WAIT_MAX     16'd10000
`define DSRF_LOOP_CHAR    8'h55
`endif

// ===== hdl/dsrf_ascii_hex.v
`timescale 1ns/1ps
// binary byte to two ascii hex characters
module dsrf_ascii_hex (
  // value
  input  wire [7:0] value,
  // characters
  output wire [7:0] hi_char,
  output wire [7:0] lo_char
);
  function [7:0] nib;
    input [3:0] n;
    begin
      if (n < 4'ha) begin
        nib = 8'h30 + {4'h0, n}; // RQ10
      end else begin
        nib = 8'h37 + {4'h0, n}; // RQ10
      end
    end
  endfunction
  assign hi_char = nib(value[7:4]);
  assign lo_char = nib(value[3:0]);
endmodule

// ===== hdl/dsrf_top.v
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "dsrf_regs.vh"
module dsrf_top (
  // apb
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // receive side, from the frame parser
  input  wire        rx_byte_valid,
  input  wire        rx_frame_start,
  input  wire        rx_frame_done,
  input  wire        rx_frame_ok,
  input  wire [7:0]  rx_node,
  input  wire [7:0]  rx_err_code,
  // loopback echo from the transceiver
  input  wire        loop_rx_valid,
  input  wire [7:0]  loop_rx_data,
  // transmit character stream
  output reg  [7:0]  tx_data,
  output reg         tx_valid,
  input  wire        tx_ready,
  // drive action on communication error
  output reg         comm_trip,
  output reg         comm_decel_stop,
  output reg         comm_coast_stop,
  output reg  [7:0]  comm_trip_code
);
  // ****************************************
  // states
  // ****************************************
  localparam [5:0] S_IDLE = 6'b000001;
  localparam [5:0] S_WAIT = 6'b000010;
  localparam [5:0] S_SEND = 6'b000100;
  localparam [5:0] S_LOOP = 6'b001000;
  localparam [5:0] S_LCHK = 6'b010000;
  localparam [5:0] S_HOLD = 6'b100000;
  localparam integer TICK_INT = `DSRF_TICK_CYC;
  localparam [16:0] TICK_CYC = TICK_INT[16:0];

  // ****************************************
  // registers
  // ****************************************
  reg [7:0]  node_addr;
  reg [7:0]  comm_speed_select;
  reg [7:0]  comm_error_action;
  reg        modbus_mode;
  reg [15:0] response_wait_time;
  reg [15:0] reception_timeout_limit;
  reg [15:0] silent_ticks;
  reg [5:0]  state;
  reg [16:0] tick_cnt;
  reg        tick;
  reg [6:0]  step_cnt;
  reg [15:0] to_cnt;
  reg        to_armed;
  reg        rx_busy;
  reg [15:0] wait_cnt;
  reg        pend_nak;
  reg [7:0]  pend_err;
  reg [7:0]  reply_node;
  reg [2:0]  idx;
  reg        loop_pass;
  reg        loop_fail;
  reg        timeout_seen;
  reg        lrx_s1;
  reg        lrx_s2;
  reg [7:0]  ldat_s1;
  reg [7:0]  ldat_s2;
  reg        lrx_s3;
  reg        por_done;
  reg        lb_req;
  reg        rep_req;
  reg        rep_nak;
  reg [7:0]  rep_err;
  reg [15:0] timeout_count;
  reg [7:0]  next_char;

  wire [7:0] na_hi;
  wire [7:0] na_lo;
  wire [7:0] ec_hi;
  wire [7:0] ec_lo;
  wire [7:0] bc_hi;
  wire [7:0] bc_lo;
  wire [7:0] chk_code;

  function [7:0] chk_fold;
    input [7:0] a;
    input [7:0] b;
    input [7:0] c;
    input [7:0] d;
    input [7:0] e;
    input       use_err;
    begin
      chk_fold = a ^ b; // RQ9
      chk_fold = chk_fold ^ c; // RQ9
      if (use_err) begin
        chk_fold = chk_fold ^ d ^ e; // RQ4
      end
    end
  endfunction

  dsrf_ascii_hex u_node (
    .value   (reply_node),
    .hi_char (na_hi),
    .lo_char (na_lo)
  );
  dsrf_ascii_hex u_err (
    .value   (pend_err),
    .hi_char (ec_hi),
    .lo_char (ec_lo)
  );
  dsrf_ascii_hex u_chk_code (
    .value   (chk_code),
    .hi_char (bc_hi),
    .lo_char (bc_lo)
  );

  // ack check leaves error chars out; nak adds them
  assign chk_code = pend_nak ?
    chk_fold(na_hi, na_lo, `DSRF_NAK, ec_hi, ec_lo, 1'b1) : // RQ4
    chk_fold(na_hi, na_lo, `DSRF_ACK, 8'h00, 8'h00, 1'b0);  // RQ2

  // ****************************************
  // apb slave
  // ****************************************
  wire apb_wr = psel & penable & pwrite & ~pready;
  wire apb_rd = psel & penable & ~pwrite & ~pready;
  wire wr_ctrl = apb_wr && (paddr == `DSRF_OFF_CTRL);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata                  <= 32'h0000_0000;
      pready                  <= 1'b0;
      pslverr                 <= 1'b0;
      node_addr               <= `DSRF_RST_ADDR;
      comm_speed_select       <= `DSRF_RST_SPEED; // RQ12
      comm_error_action       <= `DSRF_RST_ACTION;
      modbus_mode             <= 1'b0;
      response_wait_time      <= `DSRF_RST_WAIT;
      reception_timeout_limit <= `DSRF_RST_LIMIT;
      silent_ticks            <= 16'h0000;
      lb_req                  <= 1'b0;
      rep_req                 <= 1'b0;
      rep_nak                 <= 1'b0;
      rep_err                 <= 8'h00;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      lb_req  <= 1'b0;
      rep_req <= 1'b0;
      if (apb_wr) begin
        if (paddr == `DSRF_OFF_CTRL) begin
          lb_req <= pwdata[0];
        end else if (paddr == `DSRF_OFF_CONFIG) begin
          node_addr         <= pwdata[`DSRF_CFG_ADDR_LSB +: 8];
          comm_speed_select <= pwdata[`DSRF_CFG_SPEED_LSB +: 8];
          comm_error_action <= pwdata[`DSRF_CFG_ACTION_LSB +: 8];
          modbus_mode       <= pwdata[`DSRF_CFG_MODBUS_BIT];
        end else if (paddr == `DSRF_OFF_TIMING) begin
          // clamp to the legal ranges
          response_wait_time <= (pwdata[15:0] > `DSRF_WAIT_MAX) ?
            `DSRF_WAIT_MAX : pwdata[15:0]; // RQ18
          reception_timeout_limit <= (pwdata[31:16] > `DSRF_LIMIT_MAX) ?
            `DSRF_LIMIT_MAX : pwdata[31:16]; // RQ17
        end else if (paddr == `DSRF_OFF_REPLY) begin
          rep_req <= 1'b1;
          rep_nak <= pwdata[8];
          rep_err <= pwdata[7:0];
          silent_ticks <= pwdata[31:16]; // RQ19
        end else begin
          pslverr <= 1'b1;
        end
      end
      if (apb_rd) begin
        if (paddr == `DSRF_OFF_CONFIG) begin
          prdata <= {7'h00, modbus_mode, comm_error_action,
                     comm_speed_select, node_addr};
        end else if (paddr == `DSRF_OFF_TIMING) begin
          prdata <= {reception_timeout_limit, response_wait_time};
        end else if (paddr == `DSRF_OFF_REPLY) begin
          prdata <= {silent_ticks, 7'h00, rep_nak, rep_err};
        end else if (paddr == `DSRF_OFF_STATUS) begin
          prdata <= {timeout_count, 4'h0, timeout_seen, loop_fail,
                     loop_pass, to_armed, 2'b00, state};
        end else if (paddr == `DSRF_OFF_CTRL) begin
          prdata <= 32'h0000_0000;
        end else begin
          prdata  <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // 0.1 ms tick and loopback synchroniser
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 17'h00000;
      tick     <= 1'b0;
      lrx_s1   <= 1'b0;
      lrx_s2   <= 1'b0;
      lrx_s3   <= 1'b0;
      ldat_s1  <= 8'h00;
      ldat_s2  <= 8'h00;
    end else begin
      tick <= (tick_cnt == TICK_CYC - 17'h00001);
      if (tick_cnt == TICK_CYC - 17'h00001) begin
        tick_cnt <= 17'h00000;
      end else begin
        tick_cnt <= tick_cnt + 17'h00001;
      end
      lrx_s1  <= loop_rx_valid;
      lrx_s2  <= lrx_s1;
      lrx_s3  <= lrx_s2;
      ldat_s1 <= loop_rx_data;
      ldat_s2 <= ldat_s1;
    end
  end

  // ****************************************
  // reply sequencer
  // ****************************************
  always @* begin
    next_char = `DSRF_CR;
    case (idx)
      3'd0: next_char = `DSRF_STX;
      3'd1: next_char = na_hi;
      3'd2: next_char = na_lo;
      3'd3: next_char = pend_nak ? `DSRF_NAK : `DSRF_ACK; // RQ1 RQ3
      3'd4: next_char = pend_nak ? ec_hi : bc_hi;
      3'd5: next_char = pend_nak ? ec_lo : bc_lo;
      3'd6: next_char = pend_nak ? bc_hi : `DSRF_CR;
      3'd7: next_char = pend_nak ? bc_lo : `DSRF_CR;
      default: next_char = `DSRF_CR;
    endcase
  end

  wire addr_mine  = (rx_node == node_addr);
  wire addr_bcast = (rx_node == `DSRF_BCAST); // RQ8
  wire to_hit = to_armed && rx_busy && (to_cnt >= reception_timeout_limit);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state           <= S_IDLE;
      step_cnt        <= 7'h00;
      to_cnt          <= 16'h0000;
      to_armed        <= 1'b0;
      rx_busy         <= 1'b0;
      wait_cnt        <= 16'h0000;
      pend_nak        <= 1'b0;
      pend_err        <= 8'h00;
      reply_node      <= 8'h00;
      idx             <= 3'd0;
      loop_pass       <= 1'b0;
      loop_fail       <= 1'b0;
      timeout_seen    <= 1'b0;
      timeout_count   <= 16'h0000;
      tx_data         <= 8'h00;
      tx_valid        <= 1'b0;
      comm_trip       <= 1'b0;
      comm_decel_stop <= 1'b0;
      comm_coast_stop <= 1'b0;
      comm_trip_code  <= 8'h00;
      por_done        <= 1'b0;
    end else begin
      // supervision runs only while a query is being received
      if (rx_frame_start) begin
        to_armed <= 1'b1; // RQ16
        rx_busy  <= 1'b1;
        to_cnt   <= 16'h0000;
        step_cnt <= 7'h00;
      end else if (rx_busy && tick) begin // RQ16
        if (step_cnt == `DSRF_STEP_TICKS - 1) begin
          step_cnt <= 7'h00;
          to_cnt   <= to_cnt + 16'h0001; // RQ20
        end else begin
          step_cnt <= step_cnt + 7'h01;
        end
      end
      // clear first, so a timeout in the same cycle still sets the flags
      if (wr_ctrl && pwdata[1]) begin
        comm_trip       <= 1'b0;
        comm_decel_stop <= 1'b0;
        comm_coast_stop <= 1'b0;
        timeout_seen    <= 1'b0;
      end
      if (to_hit) begin
        rx_busy       <= 1'b0; // RQ14
        timeout_seen  <= 1'b1;
        timeout_count <= timeout_count + 16'h0001;
        case (comm_error_action)
          `DSRF_ACT_TRIP: begin
            comm_trip      <= 1'b1; // RQ15
            comm_trip_code <= `DSRF_ERR_TIMEOUT;
          end
          `DSRF_ACT_DECTRIP: begin
            comm_decel_stop <= 1'b1; // RQ15
            comm_trip       <= 1'b1;
            comm_trip_code  <= `DSRF_ERR_TIMEOUT;
          end
          `DSRF_ACT_COAST: begin
            comm_coast_stop <= 1'b1; // RQ15
          end
          `DSRF_ACT_DECEL: begin
            comm_decel_stop <= 1'b1; // RQ15
          end
          default: begin
          end
        endcase
      end
      tx_valid <= 1'b0;
      case (state)
        S_IDLE: begin
          if (!por_done) begin
            por_done <= 1'b1;
            if (comm_speed_select == `DSRF_SPEED_LOOP) begin
              state <= S_LOOP; // RQ11 RQ12
            end
          end else if (lb_req) begin
            state <= S_LOOP;
          end else if (rx_frame_done && rx_busy && !to_hit) begin
            rx_busy    <= 1'b0;
            reply_node <= node_addr;
            pend_nak   <= ~rx_frame_ok;
            pend_err   <= rx_err_code; // RQ5 RQ6
            wait_cnt   <= 16'h0000;
            // broadcast executes silently, others are ignored
            if (addr_mine && !addr_bcast) begin // RQ7 RQ21
              state <= S_WAIT; // RQ13
            end
          end else if (rep_req && modbus_mode) begin
            reply_node <= node_addr;
            pend_nak   <= rep_nak;
            pend_err   <= rep_err;
            wait_cnt   <= 16'h0000;
            state      <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (tick) begin
            wait_cnt <= wait_cnt + 16'h0001;
          end
          if ({1'b0, wait_cnt} >=
              {1'b0, response_wait_time} + {1'b0, silent_ticks}) begin
            idx   <= 3'd0; // RQ18 RQ19
            state <= S_SEND;
          end
        end
        S_SEND: begin
          if (tx_ready && !tx_valid) begin
            tx_data  <= next_char;
            tx_valid <= 1'b1;
            if ((idx == 3'd5 && !pend_nak) || idx == 3'd7) begin
              state <= S_HOLD;
            end else begin
              idx <= idx + 3'd1;
            end
          end
        end
        S_HOLD: begin
          if (tx_ready && !tx_valid) begin
            tx_data  <= `DSRF_CR; // RQ1 RQ3
            tx_valid <= 1'b1;
            state    <= S_IDLE;
          end
        end
        S_LOOP: begin
          // transceiver echoes our own byte, no jumper needed
          if (tx_ready) begin
            tx_data   <= `DSRF_LOOP_CHAR; // RQ11
            tx_valid  <= 1'b1;
            loop_pass <= 1'b0;
            loop_fail <= 1'b0;
            state     <= S_LCHK;
          end
        end
        S_LCHK: begin
          // second valid cycle: the data word has had a cycle to settle
          if (lrx_s2 && lrx_s3) begin
            loop_pass <= (ldat_s2 == `DSRF_LOOP_CHAR);
            loop_fail <= (ldat_s2 != `DSRF_LOOP_CHAR);
            state     <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// ===== testbench/dsrf_checker_assertions.sv
`timescale 1ns/1ps
`include "dsrf_regs.vh"
// ****
// apb, reply framer and trip checks
// ****
module dsrf_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire        pready,
  input wire        pslverr,
  input wire        rx_frame_done,
  input wire [7:0]  rx_node,
  input wire [7:0]  tx_data,
  input wire        tx_valid,
  input wire        comm_trip,
  input wire [7:0]  comm_trip_code
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_wait:
    assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("pready too long");
  a_bad_addr:
    assert property (psel && penable && pready
      && paddr > `DSRF_OFF_STATUS |-> pslverr) else $error("no slverr");
  a_tx_gap:
    assert property (tx_valid |=> !tx_valid) else $error("no idle gap");
  a_tx_chars:
    assert property (tx_valid |-> tx_data inside {8'h02, 8'h06, 8'h0d,
      8'h15, `DSRF_LOOP_CHAR, [8'h30:8'h39], [8'h41:8'h46]})
    else $error("bad tx char");
  a_tx_hold:
    assert property (!tx_valid |-> $stable(tx_data)) else $error("tx moved");
  a_bcast_quiet:
    assert property (rx_frame_done && rx_node == `DSRF_BCAST
      |=> !tx_valid [*8]) else $error("broadcast answered");
  a_trip_code:
    assert property ($rose(comm_trip) |-> comm_trip_code == 8'h08)
    else $error("bad trip code");
  a_trip_sticky:
    assert property (comm_trip && !(psel && pwrite) |=> comm_trip)
    else $error("trip dropped");
  c_ack: cover property (tx_valid && tx_data == 8'h06);
  c_nak: cover property (tx_valid && tx_data == 8'h15);
  c_trip: cover property ($rose(comm_trip));
endmodule
bind dsrf_top dsrf_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .rx_frame_done(rx_frame_done),
  .rx_node(rx_node), .tx_data(tx_data), .tx_valid(tx_valid),
  .comm_trip(comm_trip), .comm_trip_code(comm_trip_code));

// ===== testbench/dsrf_host.sv
`timescale 1ns/1ps
// ****
// host controller model
// ****
module dsrf_host (
  input  wire       pclk,
  input  wire [7:0] tx_data,
  input  wire       tx_valid,
  output reg        tx_ready,
  output reg        rx_byte_valid,
  output reg        rx_frame_start,
  output reg        rx_frame_done,
  output reg        rx_frame_ok,
  output reg  [7:0] rx_node,
  output reg  [7:0] rx_err_code,
  output reg        loop_rx_valid,
  output reg  [7:0] loop_rx_data
);
  logic [7:0] got[$];
  reg         slow;
  reg         echo;
  reg  [31:0] r;
  integer     seed;
  initial begin
    {rx_byte_valid, rx_frame_start, rx_frame_done, rx_frame_ok} = 4'h0;
    {rx_node, rx_err_code, loop_rx_data} = 24'h0;
    {loop_rx_valid, tx_ready, slow, echo} = 4'h0;
    seed = 32'h51c013c6;
  end
  // the transceiver hears its own output, so every char echoes back
  always @(posedge pclk) begin
    if (tx_valid)
      got.push_back(tx_data);
    if (tx_valid)
      loop_rx_data <= tx_data;
    echo <= tx_valid;
    loop_rx_valid <= tx_valid | echo;
    r = $random(seed);
    // a slow host stalls the stream at random
    tx_ready <= !slow | r[0];
  end
  task query(input [7:0] node, input ok, input [7:0] err, input fin);
    @(posedge pclk);
    rx_frame_start <= 1'b1;
    rx_byte_valid <= 1'b1;
    rx_node <= node;
    rx_frame_ok <= ok;
    rx_err_code <= err;
    @(posedge pclk);
    rx_frame_start <= 1'b0;
    rx_byte_valid <= 1'b0;
    rx_frame_done <= fin;
    @(posedge pclk);
    rx_frame_done <= 1'b0;
    // released lines show the inverse so stale values are never read
    rx_node <= ~node;
    rx_frame_ok <= ~ok;
    rx_err_code <= ~err;
  endtask
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`include "dsrf_regs.vh"
module testbench;
  reg         pclk, presetn, psel, penable, pwrite, er;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  reg  [7:0]  node;
  reg  [2:0]  f;
  wire [31:0] prdata;
  wire [7:0]  rx_node, rx_err_code, loop_rx_data, tx_data, comm_trip_code;
  wire        pready, pslverr, rx_byte_valid, rx_frame_start, rx_frame_done;
  wire        rx_frame_ok, loop_rx_valid, tx_valid, tx_ready, comm_trip;
  wire        comm_decel_stop, comm_coast_stop;
  integer     errors, n_tests, seed, i, k;
  logic [7:0] exp[$];
  logic [7:0] codes[11] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
                            8'h07, 8'h08, 8'h11, 8'h13, 8'h16};
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  dsrf_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_byte_valid(rx_byte_valid), .rx_frame_start(rx_frame_start),
    .rx_frame_done(rx_frame_done), .rx_frame_ok(rx_frame_ok),
    .rx_node(rx_node), .rx_err_code(rx_err_code),
    .loop_rx_valid(loop_rx_valid), .loop_rx_data(loop_rx_data),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .comm_trip(comm_trip), .comm_decel_stop(comm_decel_stop),
    .comm_coast_stop(comm_coast_stop), .comm_trip_code(comm_trip_code));
  dsrf_host u_host (.pclk(pclk), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_byte_valid(rx_byte_valid),
    .rx_frame_start(rx_frame_start), .rx_frame_done(rx_frame_done),
    .rx_frame_ok(rx_frame_ok), .rx_node(rx_node),
    .rx_err_code(rx_err_code), .loop_rx_valid(loop_rx_valid),
    .loop_rx_data(loop_rx_data));
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string what, input [31:0] e, input [31:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task ended(input string what);
    $display("test %s done, mismatches so far %0d", what, errors);
  endtask
  task give_up(input string what);
    errors = errors + 1;
    $display("BAD %s expected done seen timeout", what);
    end_of_test;
  endtask
  // master holds the request until pready is sampled high
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50 && pready !== 1'b1; k++)
      @(posedge pclk);
    if (k == 50)
      give_up("pready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic [7:0] hx(input [3:0] n);
    hx = (n < 10) ? 8'h30 + n : 8'h37 + n;
  endfunction
  task quiet;
    repeat (2000) @(posedge pclk);
    chk("silence", 0, u_host.got.size());
    u_host.got = {};
    ended("silence");
  endtask
  task frame(input [7:0] nd, input ok, input [7:0] ec);
    reg [7:0] b;
    exp = {8'h02, hx(nd[7:4]), hx(nd[3:0])};
    b = exp[1] ^ exp[2];
    if (ok) begin
      exp.push_back(8'h06);
    end else begin
      exp.push_back(8'h15);
      exp.push_back(hx(ec[7:4]));
      exp.push_back(hx(ec[3:0]));
      b = b ^ exp[4] ^ exp[5];
    end
    b = b ^ exp[3];
    exp.push_back(hx(b[7:4]));
    exp.push_back(hx(b[3:0]));
    exp.push_back(8'h0d);
    for (k = 0; k < 40000 && u_host.got.size() < exp.size(); k++)
      @(posedge pclk);
    if (k == 40000)
      give_up("reply");
    repeat (60) @(posedge pclk);
    chk("length", exp.size(), u_host.got.size());
    for (k = 0; k < exp.size(); k++)
      chk("char", exp[k], u_host.got[k]);
    u_host.got = {};
    ended("frame");
  endtask
  initial begin
    {errors, n_tests} = 0;
    seed = 32'h51c013c6;
    {psel, penable, pwrite, paddr, pwdata} = 0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `DSRF_OFF_CONFIG, 0);
    chk("speed", `DSRF_RST_SPEED, rd[15:8]);
    chk("address", `DSRF_RST_ADDR, rd[7:0]);
    apb(0, 12'h020, 0);
    chk("slverr", 1, er);
    chk("unmapped", 0, rd);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1, `DSRF_OFF_TIMING, 0);
    repeat (3000) @(posedge pclk);
    chk("idle trip", 0, comm_trip);
    ended("reset");
    apb(1, `DSRF_OFF_TIMING, {16'd9999, 16'h0000});
    for (i = 0; i < 14; i++) begin
      rd = $random(seed);
      node = {3'b000, rd[4:0]} + 8'h01;
      u_host.slow = rd[8];
      apb(1, `DSRF_OFF_CONFIG, {16'h0204, node});
      u_host.query(node, i > 10, codes[i % 11], 1'b1);
      frame(node, i > 10, codes[i % 11]);
    end
    u_host.query(`DSRF_BCAST, 1'b1, 8'h00, 1'b1);
    quiet;
    u_host.query(node ^ 8'h40, 1'b1, 8'h00, 1'b1);
    quiet;
    for (i = 0; i < 5; i++) begin
      f = {i < 2, i == 1 || i == 4, i == 3};
      apb(1, `DSRF_OFF_CONFIG, {8'h00, i[7:0], 8'h04, node});
      apb(1, `DSRF_OFF_TIMING, 0);
      u_host.query(node, 1'b1, 8'h00, 1'b0);
      for (k = 0; k < 15000 && f !== {comm_trip, comm_decel_stop,
           comm_coast_stop}; k++)
        @(posedge pclk);
      chk("action", f, {comm_trip, comm_decel_stop, comm_coast_stop});
      if (i == 0)
        chk("trip code", 8'h08, comm_trip_code);
      quiet;
      chk("action held", f, {comm_trip, comm_decel_stop, comm_coast_stop});
      apb(1, `DSRF_OFF_CTRL, 2);
      apb(1, `DSRF_OFF_TIMING, {16'd9999, 16'h0000});
      chk("clear", 0, {comm_trip, comm_decel_stop, comm_coast_stop});
      ended("action");
    end
    u_host.query(node, 1'b1, 8'h00, 1'b1);
    frame(node, 1'b1, 8'h00);
    // responder mode: nak on request, after wait 2 ticks plus silent 1 tick
    apb(1, `DSRF_OFF_CONFIG, {8'h01, 8'h04, 8'h04, node});
    apb(1, `DSRF_OFF_TIMING, {16'd9999, 16'd2});
    apb(1, `DSRF_OFF_REPLY, {16'd1, 8'h01, 8'h16});
    for (k = 0; k < 40000 && u_host.got.size() == 0; k++)
      @(posedge pclk);
    chk("wait", 1, k > 24000 && k < 38000);
    frame(node, 1'b0, 8'h16);
    apb(1, `DSRF_OFF_CONFIG, {8'h00, 8'h00, `DSRF_SPEED_LOOP, node});
    apb(1, `DSRF_OFF_CTRL, 1);
    for (i = 0; i < 5000 && rd[10:9] === 2'b00; i++)
      apb(0, `DSRF_OFF_STATUS, 0);
    chk("loopback", 2'b01, rd[10:9]);
    ended("loopback");
    end_of_test;
  end
endmodule
